// File: coproc_pkg.sv
package coproc_pkg;
    // Bus geometry and register file
    localparam int DATA_W = 16;
    localparam int NUM_FREGS = 8;
    localparam int FREG_W = 64;
    localparam int CLK_PERIOD_NS = 10;

    // Cycle status codes on the two status lines
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_OPWORD = 2'h1;
    localparam logic [1:0] CODE_WRITE = 2'h2;
    localparam logic [1:0] CODE_READ = 2'h3;

    // Operation word layout
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 12;
    localparam int DBL_BIT = 11;
    localparam int DST_MSB = 10;
    localparam int DST_LSB = 8;
    localparam int SRCMEM_BIT = 7;
    localparam int SRC_MSB = 6;
    localparam int SRC_LSB = 4;

    // Operation codes
    localparam logic [3:0] OP_ADD = 4'h0;
    localparam logic [3:0] OP_SUB = 4'h1;
    localparam logic [3:0] OP_MUL = 4'h2;
    localparam logic [3:0] OP_DIV = 4'h3;
    localparam logic [3:0] OP_MOV = 4'h4;
    localparam logic [3:0] OP_CVT = 4'h5;
    localparam logic [3:0] OP_CMP = 4'h6;

    // Status word bits
    localparam int STAT_INVALID = 0;
    localparam int STAT_DIVZERO = 1;
    localparam int STAT_EQUAL = 2;
    localparam int STAT_LESS = 3;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Timing counts in clock cycles
    localparam int RESET_LOW_CYCLES = 64;
    localparam int DONE_PULSE_CYCLES = 1;
    localparam int EXEC_CYCLES = 4;

    // Operand words that follow an operation word
    function automatic logic [2:0] operand_words(input logic [15:0] w);
        if (!w[SRCMEM_BIT]) begin
            return 3'h0;
        end
        return w[DBL_BIT] ? 3'h4 : 3'h2;
    endfunction : operand_words

    // Result words read back after the status word
    function automatic logic [2:0] result_words(input logic [15:0] w);
        if (w[OP_MSB:OP_LSB] == OP_CMP) begin
            return 3'h0;
        end
        return w[DBL_BIT] ? 3'h4 : 3'h2;
    endfunction : result_words
endpackage : coproc_pkg

// File: coproc_if.sv
`timescale 1ns/1ps
interface coproc_if;
    logic [15:0] host_data;
    logic host_data_oe;
    logic host_strobe_oe;
    logic [15:0] dev_data;
    logic dev_data_oe;
    logic dev_strobe_oe;
    logic cycle_status_bit0;
    logic cycle_status_bit1;
    logic reset_n;
    logic [15:0] data;
    logic coproc_strobe_n;

    // Bus floats high when nobody drives; device wins only in its reads
    assign data = dev_data_oe ? dev_data :
                  (host_data_oe ? host_data : 16'hFFFF);
    // Strobe is pulled up; either end may pull it low
    assign coproc_strobe_n = ~(host_strobe_oe | dev_strobe_oe);

    modport host (
        output host_data, host_data_oe, host_strobe_oe,
        output cycle_status_bit0, cycle_status_bit1, reset_n,
        input data, coproc_strobe_n
    );
    modport device (
        output dev_data, dev_data_oe, dev_strobe_oe,
        input data, coproc_strobe_n, reset_n,
        input cycle_status_bit0, cycle_status_bit1
    );
endinterface : coproc_if

// File: float_coprocessor_slave_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Host opens cycle, sends op then operands
// - Execute, then pulse strobe to report completion
// - Host reads status, traps or reads results
// - 16-bit data bus; unit drives only reads
// - Two status lines plus one strobe only
// - Host strobes every transferred word
// - Host codes each strobe on status lines
// - Low reset input holds unit in reset
// - Arithmetic, move, convert, compare, both precisions
// - Bit 15 is the word MSB
// - Eight on-chip data registers
// - Single clock for all logic
// - Host holds reset low 64 cycles
// - Completion pulse is one clock long
module float_coprocessor_slave_port #(
    parameter int EXEC_CYCLES = coproc_pkg::EXEC_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    coproc_if.device bus,
    output logic busy_o,
    output logic error_o
);
    localparam int CNT_W = $clog2(EXEC_CYCLES + 2);

    typedef enum logic [2:0] {
        S_IDLE, S_LOAD, S_EXEC, S_DONE, S_RESULT
    } state_t;

    state_t state_reg;
    logic unit_reset;
    logic strobe_prev_reg;
    logic host_edge;
    logic [1:0] code;
    logic [15:0] op_reg;
    logic [63:0] operand_reg;
    logic [2:0] words_left_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic exec_last;
    logic pulse_last;
    logic [15:0] status_reg;
    logic status_pending_reg;
    logic [63:0] res_shift_reg;
    logic [63:0] fregs [coproc_pkg::NUM_FREGS];
    logic [3:0] op;
    logic dbl;
    logic [2:0] dst;
    logic [63:0] a_full;
    logic [63:0] b_full;
    logic signed [63:0] a;
    logic signed [63:0] b;
    logic [63:0] res_raw;
    logic [63:0] res_store;
    logic res_write;
    logic [15:0] status_next;

    assign unit_reset = reset_i | ~bus.reset_n;
    assign code = {bus.cycle_status_bit1, bus.cycle_status_bit0};
    // Our own completion pulse must not look like a host strobe
    assign host_edge = strobe_prev_reg & ~bus.coproc_strobe_n &
                       ~bus.dev_strobe_oe &
                       (code != coproc_pkg::CODE_NONE);
    assign exec_last = (cnt_reg == CNT_W'(EXEC_CYCLES - 1));
    assign pulse_last = (cnt_reg == CNT_W'(coproc_pkg::DONE_PULSE_CYCLES - 1));
    assign op = op_reg[coproc_pkg::OP_MSB:coproc_pkg::OP_LSB];
    assign dbl = op_reg[coproc_pkg::DBL_BIT];
    assign dst = op_reg[coproc_pkg::DST_MSB:coproc_pkg::DST_LSB];

    // Strobe level history for edge detection
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            strobe_prev_reg <= 1'b1;
        end else begin
            strobe_prev_reg <= bus.coproc_strobe_n;
        end
    end

    // Sequencer: op word, operands, execute, report, serve reads
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            state_reg <= S_IDLE;
            op_reg <= 16'h0000;
            words_left_reg <= 3'h0;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                S_IDLE, S_RESULT, S_LOAD: begin
                    // A fresh op word restarts, abandoning old results
                    if (host_edge && code == coproc_pkg::CODE_OPWORD) begin
                        op_reg <= bus.data;
                        words_left_reg <= coproc_pkg::operand_words(bus.data);
                        cnt_reg <= '0;
                        state_reg <= (coproc_pkg::operand_words(bus.data) ==
                                      3'h0) ? S_EXEC : S_LOAD;
                    end else if (state_reg == S_LOAD && host_edge &&
                                 code == coproc_pkg::CODE_WRITE) begin
                        words_left_reg <= words_left_reg - 3'h1;
                        if (words_left_reg == 3'h1) begin
                            state_reg <= S_EXEC;
                        end
                    end
                end
                S_EXEC: begin
                    // Strobes during execution are ignored
                    cnt_reg <= cnt_reg + CNT_W'(1);
                    if (exec_last) begin
                        cnt_reg <= '0;
                        state_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    cnt_reg <= cnt_reg + CNT_W'(1);
                    if (pulse_last) begin
                        state_reg <= S_RESULT;
                    end
                end
            endcase
        end
    end

    // Operand words arrive MSB word first
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            operand_reg <= 64'h0000_0000_0000_0000;
        end else if (state_reg == S_LOAD && host_edge &&
                     code == coproc_pkg::CODE_WRITE) begin
            operand_reg <= {operand_reg[47:0], bus.data};
        end
    end

    // Execution datapath; single precision uses the low 32 bits
    always_comb begin
        a_full = fregs[dst];
        b_full = op_reg[coproc_pkg::SRCMEM_BIT] ? operand_reg :
                 fregs[op_reg[coproc_pkg::SRC_MSB:coproc_pkg::SRC_LSB]];
        a = dbl ? a_full : {{32{a_full[31]}}, a_full[31:0]};
        b = dbl ? b_full : {{32{b_full[31]}}, b_full[31:0]};
        res_raw = a;
        res_write = 1'b1;
        status_next = coproc_pkg::STATUS_RESET;
        unique case (op)
            coproc_pkg::OP_ADD: res_raw = a + b;
            coproc_pkg::OP_SUB: res_raw = a - b;
            coproc_pkg::OP_MUL: res_raw = a * b;
            coproc_pkg::OP_DIV: begin
                if (b == 64'sh0000_0000_0000_0000) begin
                    status_next[coproc_pkg::STAT_DIVZERO] = 1'b1;
                    res_write = 1'b0;
                end else begin
                    res_raw = a / b;
                end
            end
            coproc_pkg::OP_MOV: res_raw = b;
            coproc_pkg::OP_CVT: begin
                // Double target widens a single source; else narrows
                res_raw = dbl ? {{32{b_full[31]}}, b_full[31:0]} : b_full;
            end
            coproc_pkg::OP_CMP: begin
                res_write = 1'b0;
                status_next[coproc_pkg::STAT_EQUAL] = (a == b);
                status_next[coproc_pkg::STAT_LESS] = (a < b);
            end
            default: begin
                res_write = 1'b0;
                status_next[coproc_pkg::STAT_INVALID] = 1'b1;
            end
        endcase
        res_store = dbl ? res_raw : {32'h0000_0000, res_raw[31:0]};
    end

    // Register file, one writer per entry
    genvar gi;
    generate
        for (gi = 0; gi < coproc_pkg::NUM_FREGS; gi++) begin : g_freg
            always_ff @(posedge clk_i) begin
                if (unit_reset) begin
                    fregs[gi] <= 64'h0000_0000_0000_0000;
                end else if (state_reg == S_EXEC && exec_last &&
                             res_write && dst == 3'(gi)) begin
                    fregs[gi] <= res_store;
                end
            end
        end
    endgenerate

    // Status and result words captured at completion
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            status_reg <= coproc_pkg::STATUS_RESET;
            res_shift_reg <= 64'h0000_0000_0000_0000;
            status_pending_reg <= 1'b0;
            error_o <= 1'b0;
        end else if (state_reg == S_EXEC && exec_last) begin
            status_reg <= status_next;
            res_shift_reg <= dbl ? res_store :
                             {res_store[31:0], 32'h0000_0000};
            status_pending_reg <= 1'b1;
            error_o <= status_next[coproc_pkg::STAT_INVALID] |
                       status_next[coproc_pkg::STAT_DIVZERO];
        end else if (state_reg == S_RESULT && host_edge &&
                     code == coproc_pkg::CODE_READ) begin
            status_pending_reg <= 1'b0;
            if (!status_pending_reg) begin
                res_shift_reg <= {res_shift_reg[47:0], 16'h0000};
            end
        end
    end

    // Data drive: from the strobe edge until the strobe rises
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            bus.dev_data_oe <= 1'b0;
            bus.dev_data <= 16'h0000;
        end else if (state_reg == S_RESULT && host_edge &&
                     code == coproc_pkg::CODE_READ) begin
            bus.dev_data_oe <= 1'b1;
            bus.dev_data <= status_pending_reg ? status_reg :
                            res_shift_reg[63:48];
        end else if (bus.coproc_strobe_n) begin
            bus.dev_data_oe <= 1'b0;
        end
    end

    // Completion pulse on the shared strobe
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            bus.dev_strobe_oe <= 1'b0;
        end else if (state_reg == S_EXEC && exec_last) begin
            bus.dev_strobe_oe <= 1'b1;
        end else if (state_reg == S_DONE && pulse_last) begin
            bus.dev_strobe_oe <= 1'b0;
        end
    end

    // Busy covers operand loading and execution
    always_ff @(posedge clk_i) begin
        if (unit_reset) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_reg == S_LOAD) || (state_reg == S_EXEC) ||
                      (state_reg == S_DONE);
        end
    end
endmodule : float_coprocessor_slave_port

// File: float_coprocessor_host_port.sv
`timescale 1ns/1ps
module float_coprocessor_host_port (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic [15:0] op_word_i,
    input wire logic [63:0] operand_i,
    coproc_if.host bus,
    output logic busy_o,
    output logic done_o,
    output logic trap_o,
    output logic [15:0] status_o,
    output logic [63:0] result_o
);
    typedef enum logic [2:0] {
        H_RESET, H_IDLE, H_OP, H_WR, H_WAIT, H_RDS, H_RDR, H_END
    } host_state_t;

    host_state_t state_reg;
    logic [1:0] phase_reg;
    logic [6:0] rst_cnt_reg;
    logic [15:0] op_reg;
    logic [63:0] shift_reg;
    logic [2:0] left_reg;
    logic xfer;
    logic word_end;

    assign xfer = (state_reg == H_OP) || (state_reg == H_WR) ||
                  (state_reg == H_RDS) || (state_reg == H_RDR);
    assign word_end = xfer && (phase_reg == 2'h3);

    // Four phases per word: setup, strobe low twice, recover
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_reg <= 2'h0;
            bus.host_strobe_oe <= 1'b0;
        end else begin
            phase_reg <= xfer ? phase_reg + 2'h1 : 2'h0;
            bus.host_strobe_oe <= xfer &&
                                  (phase_reg == 2'h0 || phase_reg == 2'h1);
        end
    end

    // Main sequence of one coprocessor instruction
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= H_RESET;
            rst_cnt_reg <= 7'h00;
            bus.reset_n <= 1'b0;
            {bus.cycle_status_bit1, bus.cycle_status_bit0} <=
                coproc_pkg::CODE_NONE;
            bus.host_data <= 16'h0000;
            bus.host_data_oe <= 1'b0;
            op_reg <= 16'h0000;
            shift_reg <= 64'h0000_0000_0000_0000;
            left_reg <= 3'h0;
            busy_o <= 1'b1;
            done_o <= 1'b0;
            trap_o <= 1'b0;
            status_o <= coproc_pkg::STATUS_RESET;
            result_o <= 64'h0000_0000_0000_0000;
        end else begin
            done_o <= 1'b0;
            unique case (state_reg)
                H_RESET: begin
                    rst_cnt_reg <= rst_cnt_reg + 7'h01;
                    if (rst_cnt_reg ==
                        7'(coproc_pkg::RESET_LOW_CYCLES - 1)) begin
                        bus.reset_n <= 1'b1;
                        busy_o <= 1'b0;
                        state_reg <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    if (start_i) begin
                        op_reg <= op_word_i;
                        shift_reg <= op_word_i[coproc_pkg::DBL_BIT] ?
                                     operand_i :
                                     {operand_i[31:0], 32'h0000_0000};
                        left_reg <= coproc_pkg::operand_words(op_word_i);
                        bus.host_data <= op_word_i;
                        bus.host_data_oe <= 1'b1;
                        {bus.cycle_status_bit1, bus.cycle_status_bit0} <=
                            coproc_pkg::CODE_OPWORD;
                        busy_o <= 1'b1;
                        trap_o <= 1'b0;
                        state_reg <= H_OP;
                    end
                end
                H_OP, H_WR: begin
                    if (word_end && left_reg != 3'h0) begin
                        bus.host_data <= shift_reg[63:48];
                        shift_reg <= {shift_reg[47:0], 16'h0000};
                        left_reg <= left_reg - 3'h1;
                        {bus.cycle_status_bit1, bus.cycle_status_bit0} <=
                            coproc_pkg::CODE_WRITE;
                        state_reg <= H_WR;
                    end else if (word_end) begin
                        bus.host_data_oe <= 1'b0;
                        {bus.cycle_status_bit1, bus.cycle_status_bit0} <=
                            coproc_pkg::CODE_NONE;
                        state_reg <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    // Completion: strobe pulled low by the unit
                    if (!bus.coproc_strobe_n) begin
                        {bus.cycle_status_bit1, bus.cycle_status_bit0} <=
                            coproc_pkg::CODE_READ;
                        state_reg <= H_RDS;
                    end
                end
                H_RDS: begin
                    if (phase_reg == 2'h2) begin
                        status_o <= bus.data;
                    end
                    if (word_end) begin
                        left_reg <= coproc_pkg::result_words(op_reg);
                        if (status_o[coproc_pkg::STAT_INVALID] ||
                            status_o[coproc_pkg::STAT_DIVZERO]) begin
                            trap_o <= 1'b1;
                            state_reg <= H_END;
                        end else if (coproc_pkg::result_words(op_reg) ==
                                     3'h0) begin
                            state_reg <= H_END;
                        end else begin
                            state_reg <= H_RDR;
                        end
                    end
                end
                H_RDR: begin
                    if (phase_reg == 2'h2) begin
                        shift_reg <= {shift_reg[47:0], bus.data};
                    end
                    if (word_end) begin
                        left_reg <= left_reg - 3'h1;
                        if (left_reg == 3'h1) begin
                            state_reg <= H_END;
                        end
                    end
                end
                H_END: begin
                    {bus.cycle_status_bit1, bus.cycle_status_bit0} <=
                        coproc_pkg::CODE_NONE;
                    result_o <= op_reg[coproc_pkg::DBL_BIT] ? shift_reg :
                                {32'h0000_0000, shift_reg[31:0]};
                    done_o <= 1'b1;
                    busy_o <= 1'b0;
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end
endmodule : float_coprocessor_host_port

// File: coproc_chk.sv
`timescale 1ns/1ps
module coproc_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic host_data_oe,
    input wire logic host_strobe_oe,
    input wire logic dev_data_oe,
    input wire logic dev_strobe_oe,
    input wire logic cycle_status_bit0,
    input wire logic cycle_status_bit1,
    input wire logic reset_n,
    input wire logic coproc_strobe_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    logic [1:0] code;
    // Preset so the count is defined before reset_n is first seen
    logic [7:0] low_cnt_reg = 8'h00;

    assign code = {cycle_status_bit1, cycle_status_bit0};

    // Low cycles of the device reset, saturating
    always_ff @(posedge clk_i) begin
        if (reset_n) begin
            low_cnt_reg <= 8'h00;
        end else if (low_cnt_reg != 8'hFF) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
        end
    end

    chk_reset_low_len: assert property ($rose(reset_n) |->
        low_cnt_reg >= coproc_pkg::RESET_LOW_CYCLES)
        else $error("device reset released too early");
    chk_reset_quiet: assert property (!reset_n |=>
        !dev_data_oe && !dev_strobe_oe)
        else $error("device drives a line in reset");
    chk_one_driver: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the data bus");
    chk_read_only: assert property (dev_data_oe |->
        code == coproc_pkg::CODE_READ)
        else $error("device drives data outside a read");
    chk_read_strobed: assert property (dev_data_oe |->
        !$past(coproc_strobe_n))
        else $error("device drives data without a read strobe");
    chk_done_one_cycle: assert property ($rose(dev_strobe_oe) |=>
        !dev_strobe_oe)
        else $error("completion pulse not one cycle");
    chk_done_alone: assert property (dev_strobe_oe |->
        !host_strobe_oe && !dev_data_oe)
        else $error("completion overlaps a transfer");
    chk_strobe_coded: assert property ($rose(host_strobe_oe) |->
        code != coproc_pkg::CODE_NONE ##1 $stable(code) && host_strobe_oe)
        else $error("strobe without a steady status code");
    chk_strobe_shape: assert property ($rose(host_strobe_oe) |=>
        host_strobe_oe ##1 !host_strobe_oe)
        else $error("host strobe not two cycles");
endmodule : coproc_chk

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
    comparisons++; \
    if ((gt) !== (ex)) begin \
        $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
        fails++; \
    end \
end
module tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic [15:0] op_word_i = 16'h0000;
    logic [63:0] operand_i = 64'h0000_0000_0000_0000;
    logic h_busy, done_o, trap_o, d_busy, error_o;
    logic [15:0] status_o;
    logic [63:0] result_o;
    int fails = 0;
    int comparisons = 0;
    int cycle_count = 0;
    localparam logic [63:0] V = 64'h0123_4567_89AB_CDEF;

    coproc_if bus ();
    float_coprocessor_host_port float_coprocessor_host_port_i (
        .clk_i(clk_i), .reset_i(reset_i), .start_i(start_i),
        .op_word_i(op_word_i), .operand_i(operand_i), .bus(bus),
        .busy_o(h_busy), .done_o(done_o), .trap_o(trap_o),
        .status_o(status_o), .result_o(result_o));
    float_coprocessor_slave_port float_coprocessor_slave_port_i (
        .clk_i(clk_i), .reset_i(reset_i), .bus(bus),
        .busy_o(d_busy), .error_o(error_o));
    coproc_chk coproc_chk_i (
        .clk_i(clk_i), .reset_i(reset_i),
        .host_data_oe(bus.host_data_oe),
        .host_strobe_oe(bus.host_strobe_oe),
        .dev_data_oe(bus.dev_data_oe), .dev_strobe_oe(bus.dev_strobe_oe),
        .cycle_status_bit0(bus.cycle_status_bit0),
        .cycle_status_bit1(bus.cycle_status_bit1),
        .reset_n(bus.reset_n), .coproc_strobe_n(bus.coproc_strobe_n));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [15:0] mk(input logic [3:0] op,
        input logic dbl, input logic [2:0] dst, input logic mem,
        input logic [2:0] src);
        return {op, dbl, dst, mem, src, 4'h0};
    endfunction : mk

    task automatic report_and_stop();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Reset, then wait out the long device reset of the host
    task automatic t_reset();
        int n;
        n = 0;
        @(posedge clk_i); #1 reset_i = 1'b1;
        repeat (8) @(posedge clk_i);
        #1 reset_i = 1'b0;
        while (h_busy !== 1'b0 && n < 300) begin
            @(posedge clk_i); #1 n++;
        end
        `CHK("host_ready", 1'b0, h_busy)
        `CHK("dev_busy", 1'b0, d_busy)
        `CHK("dev_error", 1'b0, error_o)
    endtask : t_reset

    // One whole instruction; single results judged on the low 32 bits
    task automatic do_op(input logic [15:0] op, input logic [63:0] val,
        input logic [63:0] er, input logic [15:0] es, input logic cr);
        int n;
        logic [63:0] msk;
        logic seen_h;
        logic seen_d;
        n = 0;
        seen_h = 1'b0;
        seen_d = 1'b0;
        msk = op[11] ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
        @(posedge clk_i); #1 start_i = 1'b1;
        op_word_i = op;
        operand_i = val;
        @(posedge clk_i); #1 start_i = 1'b0;
        while (done_o !== 1'b1 && n < 400) begin
            // Both ends must show work in flight at some point
            seen_h = seen_h | (h_busy === 1'b1);
            seen_d = seen_d | (d_busy === 1'b1);
            @(posedge clk_i); #1 n++;
        end
        `CHK("done", 1'b1, done_o)
        `CHK("host_busy_seen", 1'b1, seen_h)
        `CHK("dev_busy_seen", 1'b1, seen_d)
        `CHK("host_idle", 1'b0, h_busy)
        `CHK("dev_idle", 1'b0, d_busy)
        `CHK("status", es, status_o)
        `CHK("trap", |es[1:0], trap_o)
        `CHK("error", |es[1:0], error_o)
        if (cr) begin
            `CHK("result", er & msk, result_o & msk)
        end
    endtask : do_op

    // Single precision ops on a bus operand, back to back
    task automatic t_single();
        do_op(mk(coproc_pkg::OP_MOV, 0, 1, 1, 0), 64'h8000_0001,
            64'h8000_0001, 16'h0000, 1);
        do_op(mk(coproc_pkg::OP_MOV, 0, 1, 1, 0), 64'h1234, 64'h1234,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_SUB, 0, 1, 1, 0), 64'h34, 64'h1200,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_MUL, 0, 1, 1, 0), 64'h2, 64'h2400,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_DIV, 0, 1, 1, 0), 64'h10, 64'h0240,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_ADD, 0, 1, 1, 0), 64'hFFFF_FFFF, 64'h023F,
            16'h0000, 1);
    endtask : t_single

    // Four-word values, register sources, widening and narrowing
    task automatic t_double();
        do_op(mk(coproc_pkg::OP_MOV, 1, 2, 1, 0), V, V, 16'h0000, 1);
        do_op(mk(coproc_pkg::OP_ADD, 1, 2, 0, 2), 64'h0, V + V,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_MOV, 0, 3, 0, 1), 64'h0, 64'h023F,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_CVT, 1, 4, 0, 1), 64'h0, 64'h023F,
            16'h0000, 1);
        do_op(mk(coproc_pkg::OP_CVT, 0, 7, 0, 2), 64'h0, 64'h1357_9BDE,
            16'h0000, 1);
    endtask : t_double

    // Compare reports flags only
    task automatic t_compare();
        do_op(mk(coproc_pkg::OP_CMP, 1, 2, 1, 0), V + V, 64'h0,
            16'h0004, 0);
        do_op(mk(coproc_pkg::OP_CMP, 1, 2, 1, 0), 64'h7FFF_FFFF_FFFF_FFFF,
            64'h0, 16'h0008, 0);
    endtask : t_compare

    // Faulting ops trap and leave the target alone
    task automatic t_faults();
        do_op(mk(coproc_pkg::OP_DIV, 0, 1, 1, 0), 64'h0, 64'h0,
            16'h0002, 0);
        do_op(mk(coproc_pkg::OP_MOV, 0, 5, 0, 1), 64'h0, 64'h023F,
            16'h0000, 1);
        do_op(mk(4'hF, 0, 1, 0, 1), 64'h0, 64'h0, 16'h0001, 0);
    endtask : t_faults

    // Mid-run reset clears error and registers
    task automatic t_rereset();
        t_reset();
        do_op(mk(coproc_pkg::OP_MOV, 0, 6, 0, 1), 64'h0, 64'h0,
            16'h0000, 1);
    endtask : t_rereset

    // Hang guard, generous against some 650 expected cycles
    always @(posedge clk_i) begin
        cycle_count++;
        if (cycle_count == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        t_reset();
        t_single();
        t_double();
        t_compare();
        t_faults();
        t_rereset();
        report_and_stop();
    end
endmodule : tb_top
